// ---- rtl/rsd_pkg.sv ----
// Package of the receiver status display bank: offsets, fields, types.
// Assumes an 8-bit register port on the system clock.
package rsd_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] RSD_OFS_AGC_STATUS  = 8'h2A;
    localparam logic [7:0] RSD_OFS_STRENGTH    = 8'h2B;
    localparam logic [7:0] RSD_OFS_PAGED       = 8'h2C;
    localparam logic [7:0] RSD_OFS_PAGE_SET    = 8'h40;
    localparam logic [7:0] RSD_OFS_IRQ_STATUS  = 8'h41;
    localparam logic [7:0] RSD_OFS_IRQ_ENABLE  = 8'h42;
    localparam logic [7:0] RSD_OFS_IRQ_CLEAR   = 8'h43;

    // ************************************************************
    // Field positions and fixed values
    // ************************************************************
    localparam int         RSD_POS_PHASE       = 7;
    localparam int         RSD_POS_AGC         = 4;
    localparam int         RSD_POS_CHAN        = 3;
    localparam int         RSD_POS_CARRIER_STABLE_FLAG       = 2;
    localparam int         RSD_POS_PLL_OK      = 1;
    localparam int         RSD_POS_OSC_OK      = 0;
    localparam int         RSD_POS_STR_PAGE    = 0;
    localparam int         RSD_POS_STAT_PAGE   = 4;
    localparam logic [2:0] RSD_GAIN_LIMIT_MAX  = 3'h4;
    localparam logic [7:0] RSD_RESET_BYTE      = 8'h00;
    localparam logic [4:0] RSD_IRQ_RESET       = 5'h00;
    localparam int         RSD_IRQ_N           = 5;

    // ************************************************************
    // Page codes
    // ************************************************************
    localparam logic [3:0] RSD_STR_REALTIME    = 4'h0;
    localparam logic [3:0] RSD_STR_NOISE       = 4'h2;
    localparam logic [3:0] RSD_STR_PILOT       = 4'h4;
    localparam logic [3:0] RSD_STR_PEAK        = 4'h8;
    localparam logic [3:0] RSD_STR_COLL_TIME   = 4'hC;
    localparam logic [3:0] RSD_STR_COLL_LEN    = 4'hD;
    localparam logic [3:0] RSD_STR_ERR_TIME    = 4'hE;
    localparam logic [1:0] RSD_PG_GAIN_LIMIT   = 2'h0;
    localparam logic [1:0] RSD_PG_VCO          = 2'h1;
    localparam logic [1:0] RSD_PG_FILTER       = 2'h2;

    // One strength reading: Q high nibble, I low nibble
    typedef struct packed {
        logic [3:0] q;
        logic [3:0] i;
    } rsd_strength_t;

    // Receiver front-end status as delivered by the analog side
    typedef struct packed {
        logic       in_phase;
        logic [2:0] agc;
        logic       chan_q;
        logic       carrier_stable_flag;
        logic       pll_locked;
        logic       osc_stable;
    } rsd_rx_status_t;

    typedef struct packed {
        logic [2:0] limit_q;
        logic [2:0] limit_i;
        logic [3:0] vco_result;
        logic [2:0] vco_pin;
        logic [3:0] highpass_cal_code;
        logic [3:0] lowpass_cal_code;
    } rsd_cal_status_t;

    // Indices of sticky events
    typedef enum logic [2:0] {
        RSD_EV_RF_UP   = 3'h0,
        RSD_EV_RF_DOWN = 3'h1,
        RSD_EV_PLL_UP  = 3'h2,
        RSD_EV_PLL_DN  = 3'h3,
        RSD_EV_OSC_UP  = 3'h4
    } rsd_event_t;

    typedef enum logic [1:0] {
        RSD_RX_IDLE = 2'b01,
        RSD_RX_HOLD = 2'b10
    } rsd_rx_state_t;

endpackage

// ---- rtl/rsd_sync.sv ----
// Two flip-flop synchroniser, one per bit.
// Assumes inputs asynchronous to the clock; output lags by two edges.
`timescale 1ns/1ps
module rsd_sync
    import rsd_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ---- rtl/rsd_bank.sv ----
// Receiver status display bank: paged read-only status registers.
// Assumes status inputs come asynchronously from the analog front end
// and a single-cycle register port master on CLK_SYS.
//
// Operation
// R1: Bit 7 of 2Ah shows whether the two sub-carriers are in phase.
// R2: Bits 6..4 of 2Ah show the three-bit gain control state.
// R3: Bit 3 shows decoder channel, held from reception start to next transmit.
// R4: Bit 2 is set while the carrier level is stable.
// R5: Bit 1 is set while the synthesizer loop is locked.
// R6: Bit 0 is set once the reference oscillator is stable.
// R7: Strength register: Q reading in upper nibble, I in lower nibble.
// R8: The strength page field picks which strength reading is shown.
// R9: Address 2Ch view is chosen by a two-bit status page field.
// R10: Page 00 shows Q gain limit in bits 5..3, I in 2..0.
// R11: Gain limit codes above four act as the highest level.
// R12: Page 01 holds VCO range result in upper nibble, bit 3 reads one.
// R13: Page 01 bits 2..0 hold the VCO tuning pin measurement.
// R14: Page 10 shows highpass code high nibble, lowpass low nibble.
// R15: Page 00 upper two bits always read zero.
// R16: Strength page codes map to seven readings; others unused.
// R17: Reads have no side effects; writes to display addresses ignored.
`timescale 1ns/1ps
module rsd_bank
    import rsd_pkg::*;
(
    input  wire logic            CLK_SYS,
    input  wire logic            SRST,
    input  wire logic [7:0]      ADDR,
    input  wire logic [7:0]      WDATA,
    input  wire logic            WR,
    input  wire logic            RD,
    output logic      [7:0]      RDATA,
    output logic                 IRQ,
    input  wire rsd_rx_status_t  RX_STATUS,
    input  wire rsd_cal_status_t CAL_STATUS,
    input  wire logic            RX_START,
    input  wire logic            TX_START,
    input  wire rsd_strength_t   STR_REALTIME,
    input  wire rsd_strength_t   STR_NOISE,
    input  wire rsd_strength_t   STR_PILOT,
    input  wire rsd_strength_t   STR_PEAK,
    input  wire logic [7:0]      STR_COLL_TIME,
    input  wire logic [7:0]      STR_COLL_LEN,
    input  wire logic [7:0]      STR_ERR_TIME,
    output logic                 LIMIT_ACTIVE_Q,
    output logic                 LIMIT_ACTIVE_I
);

    // ************************************************************
    // Input synchronisation
    // ************************************************************
    localparam int SW = $bits(rsd_rx_status_t) + $bits(rsd_cal_status_t)
                      + 2 + 4 * $bits(rsd_strength_t) + 24;

    logic [SW-1:0]   sync_in;
    logic [SW-1:0]   sync_out;
    rsd_rx_status_t  rx_s;
    rsd_cal_status_t cal_s;
    logic            rx_start_s;
    logic            tx_start_s;
    rsd_strength_t   s_rt;
    rsd_strength_t   s_ns;
    rsd_strength_t   s_pl;
    rsd_strength_t   s_pk;
    logic [7:0]      s_ct;
    logic [7:0]      s_cl;
    logic [7:0]      s_et;

    assign sync_in = {RX_STATUS, CAL_STATUS, RX_START, TX_START,
                      STR_REALTIME, STR_NOISE, STR_PILOT, STR_PEAK,
                      STR_COLL_TIME, STR_COLL_LEN, STR_ERR_TIME};

    rsd_sync #(
        .W (SW)
    ) u_sync (
        .clk  (CLK_SYS),
        .srst (SRST),
        .d    (sync_in),
        .q    (sync_out)
    );

    assign {rx_s, cal_s, rx_start_s, tx_start_s,
            s_rt, s_ns, s_pl, s_pk, s_ct, s_cl, s_et} = sync_out;

    // ************************************************************
    // Decoder channel hold
    // ************************************************************
    // Channel is latched at reception start and frozen until the next
    // transmission, so a mid-frame switch upstream never shows.
    rsd_rx_state_t rx_state_q;
    rsd_rx_state_t rx_state_d;
    logic          rx_start_d1_q;
    logic          tx_start_d1_q;
    logic          chan_q;
    logic          chan_d;
    wire           rx_rise = rx_start_s & ~rx_start_d1_q;
    wire           tx_rise = tx_start_s & ~tx_start_d1_q;

    always_comb begin
        rx_state_d = rx_state_q;
        chan_d     = chan_q;
        case (rx_state_q)
            RSD_RX_IDLE: begin
                chan_d = rx_s.chan_q;
                if (rx_rise) begin
                    rx_state_d = RSD_RX_HOLD; // R3
                end
            end
            RSD_RX_HOLD: begin
                if (tx_rise) begin
                    rx_state_d = RSD_RX_IDLE; // R3
                end
            end
            default: begin
                rx_state_d = RSD_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rx_state_q    <= RSD_RX_IDLE;
            chan_q        <= 1'b0;
            rx_start_d1_q <= 1'b0;
            tx_start_d1_q <= 1'b0;
        end else begin
            rx_state_q    <= rx_state_d;
            chan_q        <= chan_d;
            rx_start_d1_q <= rx_start_s;
            tx_start_d1_q <= tx_start_s;
        end
    end

    // ************************************************************
    // Address decode
    // ************************************************************
    wire sel_agc  = ADDR == RSD_OFS_AGC_STATUS;
    wire sel_str  = ADDR == RSD_OFS_STRENGTH;
    wire sel_pg   = ADDR == RSD_OFS_PAGED;
    wire sel_set  = ADDR == RSD_OFS_PAGE_SET;
    wire sel_ist  = ADDR == RSD_OFS_IRQ_STATUS;
    wire sel_ien  = ADDR == RSD_OFS_IRQ_ENABLE;
    wire sel_icl  = ADDR == RSD_OFS_IRQ_CLEAR;

    // Display addresses have no write decode at all
    wire wr_set   = WR & sel_set; // R17
    wire wr_ien   = WR & sel_ien;
    wire wr_icl   = WR & sel_icl;

    // ************************************************************
    // Page setting register
    // ************************************************************
    logic [3:0] strength_page_select_q;
    logic [1:0] status_page_select_q;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            strength_page_select_q <= 4'h0;
            status_page_select_q   <= 2'h0;
        end else if (wr_set) begin
            strength_page_select_q <= WDATA[RSD_POS_STR_PAGE +: 4];
            status_page_select_q   <= WDATA[RSD_POS_STAT_PAGE +: 2];
        end
    end

    // ************************************************************
    // Display views
    // ************************************************************
    logic [7:0] agc_view;
    logic [7:0] str_view;
    logic [7:0] pg0_view;
    logic [7:0] pg1_view;
    logic [7:0] pg2_view;
    logic [7:0] pg_view;
    logic [2:0] lim_q_eff;
    logic [2:0] lim_i_eff;

    always_comb begin
        agc_view                   = 8'h00;
        agc_view[RSD_POS_PHASE]    = rx_s.in_phase; // R1
        agc_view[RSD_POS_AGC +: 3] = rx_s.agc; // R2
        agc_view[RSD_POS_CHAN]     = chan_q; // R3
        agc_view[RSD_POS_CARRIER_STABLE_FLAG]    = rx_s.carrier_stable_flag; // R4
        agc_view[RSD_POS_PLL_OK]   = rx_s.pll_locked; // R5
        agc_view[RSD_POS_OSC_OK]   = rx_s.osc_stable; // R6
    end

    // Unused strength codes read zero
    always_comb begin
        case (strength_page_select_q) // R7 R8
            RSD_STR_REALTIME:  str_view = s_rt; // R16
            RSD_STR_NOISE:     str_view = s_ns; // R16
            RSD_STR_PILOT:     str_view = s_pl; // R16
            RSD_STR_PEAK:      str_view = s_pk; // R16
            RSD_STR_COLL_TIME: str_view = s_ct; // R16
            RSD_STR_COLL_LEN:  str_view = s_cl; // R16
            RSD_STR_ERR_TIME:  str_view = s_et; // R16
            default:           str_view = 8'h00;
        endcase
    end
    // Struct packing puts Q in 7..4 and I in 3..0

    // Codes 5..7 are shown as read but behave as the top level
    assign lim_q_eff = (cal_s.limit_q > RSD_GAIN_LIMIT_MAX) ?
                       RSD_GAIN_LIMIT_MAX : cal_s.limit_q; // R11
    assign lim_i_eff = (cal_s.limit_i > RSD_GAIN_LIMIT_MAX) ?
                       RSD_GAIN_LIMIT_MAX : cal_s.limit_i; // R11

    assign pg0_view = {2'b00, cal_s.limit_q, cal_s.limit_i}; // R10 R15
    assign pg1_view = {cal_s.vco_result, 1'b1, cal_s.vco_pin}; // R12 R13
    assign pg2_view = {cal_s.highpass_cal_code,
                       cal_s.lowpass_cal_code}; // R14

    always_comb begin
        case (status_page_select_q) // R9
            RSD_PG_GAIN_LIMIT: pg_view = pg0_view;
            RSD_PG_VCO:        pg_view = pg1_view;
            RSD_PG_FILTER:     pg_view = pg2_view;
            default:           pg_view = 8'h00;
        endcase
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic [RSD_IRQ_N-1:0] irq_stat_q;
    logic [RSD_IRQ_N-1:0] irq_en_q;
    logic [RSD_IRQ_N-1:0] ev;
    logic                 rf_d1_q;
    logic                 pll_d1_q;
    logic                 osc_d1_q;

    assign ev[RSD_EV_RF_UP]   = rx_s.carrier_stable_flag & ~rf_d1_q;
    assign ev[RSD_EV_RF_DOWN] = ~rx_s.carrier_stable_flag & rf_d1_q;
    assign ev[RSD_EV_PLL_UP]  = rx_s.pll_locked & ~pll_d1_q;
    assign ev[RSD_EV_PLL_DN]  = ~rx_s.pll_locked & pll_d1_q;
    assign ev[RSD_EV_OSC_UP]  = rx_s.osc_stable & ~osc_d1_q;

    genvar gi;
    generate
        for (gi = 0; gi < RSD_IRQ_N; gi++) begin : g_irq
            // Set wins over a clear in the same cycle
            always_ff @(posedge CLK_SYS) begin
                if (SRST) begin
                    irq_stat_q[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    irq_stat_q[gi] <= 1'b1;
                end else if (wr_icl && WDATA[gi]) begin
                    irq_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            irq_en_q <= RSD_IRQ_RESET;
            rf_d1_q  <= 1'b0;
            pll_d1_q <= 1'b0;
            osc_d1_q <= 1'b0;
            IRQ      <= 1'b0;
        end else begin
            if (wr_ien) begin
                irq_en_q <= WDATA[RSD_IRQ_N-1:0];
            end
            rf_d1_q  <= rx_s.carrier_stable_flag;
            pll_d1_q <= rx_s.pll_locked;
            osc_d1_q <= rx_s.osc_stable;
            IRQ      <= |(irq_stat_q & irq_en_q);
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    logic [7:0] rd_mux;

    // Reads only select; no state changes on a read
    always_comb begin
        rd_mux = 8'h00;
        if (sel_agc) rd_mux = agc_view; // R17
        if (sel_str) rd_mux = str_view;
        if (sel_pg)  rd_mux = pg_view;
        if (sel_set) rd_mux = {2'b00, status_page_select_q,
                               strength_page_select_q};
        if (sel_ist) rd_mux = {3'b000, irq_stat_q};
        if (sel_ien) rd_mux = {3'b000, irq_en_q};
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            RDATA          <= RSD_RESET_BYTE;
            LIMIT_ACTIVE_Q <= 1'b0;
            LIMIT_ACTIVE_I <= 1'b0;
        end else begin
            RDATA          <= RD ? rd_mux : RSD_RESET_BYTE;
            LIMIT_ACTIVE_Q <= lim_q_eff != 3'h0;
            LIMIT_ACTIVE_I <= lim_i_eff != 3'h0;
        end
    end

endmodule

// ---- dv/rsd_fe_model.sv ----
// Front-end model: drives the seven strength readings from one base byte.
// Assumes the bench sets the base; each reading is base plus k times 11h.
`timescale 1ns/1ps
module rsd_fe_model
    import rsd_pkg::*;
(
    input  wire logic    clk,
    input  wire logic [7:0] base,
    output rsd_strength_t str_rt,
    output rsd_strength_t str_noise,
    output rsd_strength_t str_pilot,
    output rsd_strength_t str_peak,
    output logic [7:0]   coll_time,
    output logic [7:0]   coll_len,
    output logic [7:0]   err_time
);
    // Distinct values per reading, so a wrong page select shows
    always_ff @(posedge clk) begin
        str_rt    <= base;
        str_noise <= base + 8'h11;
        str_pilot <= base + 8'h22;
        str_peak  <= base + 8'h33;
        coll_time <= base + 8'h44;
        coll_len  <= base + 8'h55;
        err_time  <= base + 8'h66;
    end
endmodule

// ---- dv/rsd_bank_sva.sv ----
// Checker of the display bank, sees only the top module's ports.
// Assumes inputs held steady for a few cycles before the views are read.
`timescale 1ns/1ps
module rsd_bank_sva
    import rsd_pkg::*;
(
    input wire logic            CLK_SYS,
    input wire logic            SRST,
    input wire logic [7:0]      ADDR,
    input wire logic [7:0]      WDATA,
    input wire logic            WR,
    input wire logic            RD,
    input wire logic [7:0]      RDATA,
    input wire rsd_rx_status_t  RX_STATUS,
    input wire rsd_cal_status_t CAL_STATUS,
    input wire rsd_strength_t   STR_REALTIME,
    input wire logic            LIMIT_ACTIVE_Q,
    input wire logic            LIMIT_ACTIVE_I
);
    logic [36:0]     all_w;
    logic [36:0]     prev_q;
    logic [2:0]      cnt_q;
    logic [2:0]      cnt_d;
    logic [5:0]      page_q;
    logic            settled;
    rsd_rx_status_t  rx_q;
    rsd_cal_status_t cal_q;
    rsd_strength_t   rt_q;
    assign all_w = {RX_STATUS, CAL_STATUS, STR_REALTIME};
    // Synchronisers lag, so only judge views after steady inputs
    assign cnt_d = (all_w != prev_q) ? 3'h0 :
                   (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
    // Also stable this cycle, or the lagging views lose to a fresh change
    assign settled = cnt_q >= 3'h4 && all_w == prev_q;
    always_ff @(posedge CLK_SYS) begin
        prev_q <= all_w;
        rx_q   <= RX_STATUS;
        cal_q  <= CAL_STATUS;
        rt_q   <= STR_REALTIME;
        if (SRST) begin
            cnt_q  <= 3'h0;
            page_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;
            if (WR && ADDR == RSD_OFS_PAGE_SET) begin
                page_q <= WDATA[5:0];
            end
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    a_rdata_idle: assert property (
        !$past(RD) |-> RDATA == 8'h00) else $error("read data not idle");
    a_status_view: assert property (
        RD && ADDR == RSD_OFS_AGC_STATUS && settled |=>
        {RDATA[7:4], RDATA[2:0]} == {rx_q.in_phase, rx_q.agc,
        rx_q.carrier_stable_flag, rx_q.pll_locked, rx_q.osc_stable})
        else $error("status view wrong");
    a_str_live: assert property (
        RD && ADDR == RSD_OFS_STRENGTH && page_q[3:0] == 4'h0 && settled
        |=> RDATA == rt_q) else $error("live strength wrong");
    a_str_unused: assert property (
        RD && ADDR == RSD_OFS_STRENGTH && page_q[3:0] == 4'h1
        |=> RDATA == 8'h00) else $error("unused strength page not zero");
    a_limit_view: assert property (
        RD && ADDR == RSD_OFS_PAGED && page_q[5:4] == 2'h0 && settled |=>
        RDATA == {2'b00, cal_q.limit_q, cal_q.limit_i})
        else $error("limit view wrong");
    a_vco_view: assert property (
        RD && ADDR == RSD_OFS_PAGED && page_q[5:4] == 2'h1 && settled |=>
        RDATA == {cal_q.vco_result, 1'b1, cal_q.vco_pin})
        else $error("vco view wrong");
    a_filt_view: assert property (
        RD && ADDR == RSD_OFS_PAGED && page_q[5:4] == 2'h2 && settled |=>
        RDATA == {cal_q.highpass_cal_code, cal_q.lowpass_cal_code})
        else $error("filter view wrong");
    a_unmapped_rd: assert property (
        RD && ADDR == 8'h10 |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_limit_act: assert property (
        settled |-> LIMIT_ACTIVE_Q == (CAL_STATUS.limit_q != 3'h0) &&
        LIMIT_ACTIVE_I == (CAL_STATUS.limit_i != 3'h0))
        else $error("limit active flag wrong");
endmodule

bind rsd_bank rsd_bank_sva u_sva (.CLK_SYS(CLK_SYS), .SRST(SRST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .RX_STATUS(RX_STATUS), .CAL_STATUS(CAL_STATUS),
    .STR_REALTIME(STR_REALTIME), .LIMIT_ACTIVE_Q(LIMIT_ACTIVE_Q),
    .LIMIT_ACTIVE_I(LIMIT_ACTIVE_I));

// ---- dv/receiver_status_display_bank_tb.sv ----
// Testbench of the display bank: register reads and writes with expectations.
// Assumes the front-end model drives the strength inputs.
`timescale 1ns/1ps
module receiver_status_display_bank_tb
    import rsd_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic irq;
    logic lim_q;
    logic lim_i;
    rsd_rx_status_t rx = 8'h00;
    rsd_cal_status_t cal = '0;
    logic rx_start = 1'b0;
    logic tx_start = 1'b0;
    logic [7:0] base = 8'h21;
    rsd_strength_t s_rt, s_no, s_pi, s_pk;
    logic [7:0] s_ct, s_cl, s_et;
    int err_count = 0;
    int comparisons = 0;
    always #20 clk = ~clk;
    rsd_fe_model fe (.clk(clk), .base(base), .str_rt(s_rt), .str_noise(s_no),
        .str_pilot(s_pi), .str_peak(s_pk), .coll_time(s_ct),
        .coll_len(s_cl), .err_time(s_et));
    rsd_bank uut (.CLK_SYS(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .RX_STATUS(rx),
        .CAL_STATUS(cal), .RX_START(rx_start), .TX_START(tx_start),
        .STR_REALTIME(s_rt), .STR_NOISE(s_no), .STR_PILOT(s_pi),
        .STR_PEAK(s_pk), .STR_COLL_TIME(s_ct), .STR_COLL_LEN(s_cl),
        .STR_ERR_TIME(s_et), .LIMIT_ACTIVE_Q(lim_q), .LIMIT_ACTIVE_I(lim_i));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic settle();
        repeat (5) @(posedge clk);
    endtask
    // Reading index per strength page code; unused codes expect 00h
    function automatic logic [7:0] exp_str(input logic [3:0] c);
        logic [7:0] k;
        case (c)
            RSD_STR_REALTIME:  k = 8'h00;
            RSD_STR_NOISE:     k = 8'h01;
            RSD_STR_PILOT:     k = 8'h02;
            RSD_STR_PEAK:      k = 8'h03;
            RSD_STR_COLL_TIME: k = 8'h04;
            RSD_STR_COLL_LEN:  k = 8'h05;
            RSD_STR_ERR_TIME:  k = 8'h06;
            default:           return 8'h00;
        endcase
        return base + k * 8'h11;
    endfunction
    task automatic summarize();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        summarize();
    end
    initial begin
        static logic [7:0] sv [3] = '{8'hB5, 8'h62, 8'h1F};
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        foreach (sv[i]) begin
            rx <= sv[i];
            settle();
            chk_rd(RSD_OFS_AGC_STATUS, sv[i]);
        end
        // Channel bit frozen from reception start to next transmit
        rx <= 8'h08;
        settle();
        rx_start <= 1'b1;
        settle();
        rx <= 8'h00;
        settle();
        chk_rd(RSD_OFS_AGC_STATUS, 8'h08);
        tx_start <= 1'b1;
        settle();
        chk_rd(RSD_OFS_AGC_STATUS, 8'h00);
        wr_reg(RSD_OFS_AGC_STATUS, 8'hFF);
        chk_rd(RSD_OFS_AGC_STATUS, 8'h00);
        $display("status test done");
        for (int c = 0; c < 16; c++) begin
            wr_reg(RSD_OFS_PAGE_SET, {4'h0, 4'(c)});
            chk_rd(RSD_OFS_STRENGTH, exp_str(4'(c)));
        end
        wr_reg(RSD_OFS_STRENGTH, 8'h5A);
        chk_rd(RSD_OFS_STRENGTH, exp_str(4'hF));
        $display("strength test done");
        cal <= {3'h5, 3'h2, 4'hA, 3'h6, 4'h9, 4'h3};
        settle();
        wr_reg(RSD_OFS_PAGE_SET, 8'h00);
        chk_rd(RSD_OFS_PAGED, 8'h2A);
        check({6'h00, lim_q, lim_i}, 8'h03);
        wr_reg(RSD_OFS_PAGE_SET, 8'h10);
        chk_rd(RSD_OFS_PAGED, 8'hAE);
        wr_reg(RSD_OFS_PAGE_SET, 8'h20);
        chk_rd(RSD_OFS_PAGED, 8'h93);
        wr_reg(RSD_OFS_PAGE_SET, 8'h30);
        chk_rd(RSD_OFS_PAGED, 8'h00);
        chk_rd(RSD_OFS_PAGE_SET, 8'h30);
        cal <= {3'h0, 3'h7, 4'h0, 3'h0, 4'h0, 4'h0};
        wr_reg(RSD_OFS_PAGE_SET, 8'h00);
        settle();
        chk_rd(RSD_OFS_PAGED, 8'h07);
        check({6'h00, lim_q, lim_i}, 8'h01);
        chk_rd(8'h10, 8'h00);
        $display("paged test done");
        rx <= 8'h00;
        settle();
        // Earlier status steps raised every flag edge at least once
        chk_rd(RSD_OFS_IRQ_STATUS, 8'h1F);
        wr_reg(RSD_OFS_IRQ_CLEAR, 8'h1F);
        chk_rd(RSD_OFS_IRQ_STATUS, 8'h00);
        wr_reg(RSD_OFS_IRQ_ENABLE, 8'h01);
        rx <= 8'h04;
        settle();
        check({7'h00, irq}, 8'h01);
        chk_rd(RSD_OFS_IRQ_STATUS, 8'h01);
        wr_reg(RSD_OFS_IRQ_CLEAR, 8'h01);
        repeat (2) @(posedge clk);
        check({7'h00, irq}, 8'h00);
        wr_reg(RSD_OFS_IRQ_ENABLE, 8'h00);
        rx <= 8'h00;
        settle();
        check({7'h00, irq}, 8'h00);
        chk_rd(RSD_OFS_IRQ_STATUS, 8'h02);
        wr_reg(RSD_OFS_IRQ_ENABLE, 8'h02);
        repeat (2) @(posedge clk);
        check({7'h00, irq}, 8'h01);
        chk_rd(RSD_OFS_IRQ_ENABLE, 8'h02);
        chk_rd(RSD_OFS_IRQ_CLEAR, 8'h00);
        $display("interrupt test done");
        summarize();
    end
endmodule
